/* rtl/uiifc_pkg.sv */
// Function
// - Upper interrupt enable bits change only while the gate bit is set.
// - Divisor upper byte, offset 1 under latch select except at line control 0xBF; only power-on clears.
// - Ident bit 0 is one when none pending; resets to 01; offset 2.
// - Line status 000110, timeout 001100, rx 000100, tx 000010, modem 000000.
// - Input pin change reports ident 110000 at priority five.
// - Flow-stop or special character reports ident 010000 at priority six.
// - Handshake line going inactive reports ident 100000 at priority seven.
// - Bit 4: flow-resume clears a flow-stop, an ident read clears a special.
// - FIFO control at offset 2, written with latch select zero, resets 00.
// - Control bits 7:6 pick receive trigger of 8, 16, 56 or 60 characters.
// - Control bits 5:4 pick transmit trigger of 8, 16, 32 or 56 spaces.
// - Transmit trigger field changes only while enhanced gate bit is set.
// - Control bit 2 empties transmit FIFO, keeps shifter, then self-clears.
// - Control bit 1 empties receive FIFO, keeps shifter, then self-clears.
// - FIFO enable zero: one character each, other bits locked, trigger one.
// - FIFO enable one: both FIFOs enabled with 64 characters each.
// - Enhanced features only at line control 0xBF with hide bit clear.
package uiifc_pkg;
   localparam logic [3:0] UIIFC_OFS_DIVISOR_HIGH = 4'h1;
   localparam logic [3:0] UIIFC_OFS_INT_ENABLE   = 4'h1;
   localparam logic [3:0] UIIFC_OFS_IDENT        = 4'h2;
   localparam logic [3:0] UIIFC_OFS_FIFO_CTRL    = 4'h2;
   localparam logic [3:0] UIIFC_OFS_ENH_FEAT     = 4'h2;
   localparam int         UIIFC_LC_LATCH_BIT     = 7;
   localparam logic [7:0] UIIFC_LC_ENH_KEY       = 8'hBF;
   localparam int         UIIFC_EF_GATE_BIT      = 4;
   localparam int         UIIFC_FC_ENABLE_BIT    = 0;
   localparam int         UIIFC_FC_RXRST_BIT     = 1;
   localparam int         UIIFC_FC_TXRST_BIT     = 2;
   localparam int         UIIFC_FC_RSVD_BIT      = 3;
   localparam int         UIIFC_IE_XOFF_BIT      = 5;
   localparam int         UIIFC_IE_RTS_BIT       = 6;
   localparam int         UIIFC_IE_CTS_BIT       = 7;
   localparam logic [7:0] UIIFC_RST_DIVISOR_HIGH = 8'h00;
   localparam logic [7:0] UIIFC_RST_IDENT        = 8'h01;
   localparam logic [7:0] UIIFC_RST_FIFO_CTRL    = 8'h00;
   localparam logic [7:0] UIIFC_RST_INT_ENABLE   = 8'h00;
   localparam logic [7:0] UIIFC_RST_ENH_FEAT     = 8'h00;
   localparam logic [7:0] UIIFC_IE_LOCK_MASK     = 8'hF0;
   localparam logic [7:0] UIIFC_FC_TXTRIG_MASK   = 8'h30;
   localparam logic [7:0] UIIFC_FC_WRITE_MASK    = 8'hF1;
   // Source index order is priority order, index 0 is the most urgent.
   localparam int         UIIFC_NUM_SRC          = 8;
   localparam logic [7:0][5:0] UIIFC_IDENT_CODE  = {
      6'h20, 6'h10, 6'h30, 6'h00, 6'h02, 6'h04, 6'h0C, 6'h06};
   localparam logic [5:0] UIIFC_IDENT_NONE       = 6'h01;
   localparam logic [3:0][6:0] UIIFC_RX_TRIG     = {
      7'h3C, 7'h38, 7'h10, 7'h08};
   localparam logic [3:0][6:0] UIIFC_TX_TRIG     = {
      7'h38, 7'h20, 7'h10, 7'h08};
   localparam logic [6:0] UIIFC_TRIG_SINGLE      = 7'h01;
   localparam logic [6:0] UIIFC_DEPTH_FIFO       = 7'h40;
   localparam logic [6:0] UIIFC_DEPTH_SINGLE     = 7'h01;
endpackage

/* rtl/uiifc_ident_enc.sv */
`timescale 1ns/1ps
module uiifc_ident_enc (
   input  wire logic       clk_sys_in,
   input  wire logic       arst_n_in,
   input  wire logic [7:0] src_in,
   output logic      [5:0] ident_out
);
   logic [5:0] ident_nxt;

   always_comb begin
      ident_nxt = uiifc_pkg::UIIFC_IDENT_NONE;
      // Walk from lowest to highest priority so the most urgent wins.
      for (int i = uiifc_pkg::UIIFC_NUM_SRC - 1; i >= 0; i--) begin
         if (src_in[i]) begin
            ident_nxt = uiifc_pkg::UIIFC_IDENT_CODE[i];
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ident_out <= uiifc_pkg::UIIFC_RST_IDENT[5:0];
      end else begin
         ident_out <= ident_nxt;
      end
   end
endmodule

/* rtl/uiifc_regs.sv */
`timescale 1ns/1ps
module uiifc_regs (
   input  wire logic       clk_sys_in,
   input  wire logic       arst_n_in,
   input  wire logic       soft_reset_in,
   input  wire logic [3:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic [7:0] line_control_in,
   input  wire logic       supp_efr_hide_in,
   input  wire logic       src_line_status_in,
   input  wire logic       src_rx_timeout_in,
   input  wire logic       src_rx_data_in,
   input  wire logic       src_tx_ready_in,
   input  wire logic       src_modem_in,
   input  wire logic       src_pin_change_in,
   input  wire logic       flow_stop_det_in,
   input  wire logic       flow_resume_det_in,
   input  wire logic       special_char_det_in,
   input  wire logic       cts_inactive_in,
   input  wire logic       rts_inactive_in,
   output logic      [7:0] reg_rdata_out,
   output logic      [7:0] divisor_high_byte_out,
   output logic      [7:0] interrupt_enable_out,
   output logic      [7:0] enhanced_features_out,
   output logic      [7:0] fifo_control_out,
   output logic            tx_fifo_reset_out,
   output logic            rx_fifo_reset_out,
   output logic      [6:0] rx_trigger_out,
   output logic      [6:0] tx_trigger_out,
   output logic      [6:0] fifo_depth_out,
   output logic            int_pending_out
);
   logic       latch_sel;
   logic       enh_sel;
   logic       gate_on;
   logic       wr_dlh;
   logic       wr_ier;
   logic       wr_fcr;
   logic       wr_efr;
   logic       rd_iir;
   logic       xoff_flag_r;
   logic       spec_flag_r;
   logic [7:0] src_gated;
   logic [5:0] ident_code;
   logic [7:0] ident_val;
   logic [7:0] fcr_nxt;
   logic [7:0] rdata_nxt;

   assign latch_sel = line_control_in[uiifc_pkg::UIIFC_LC_LATCH_BIT];
   assign enh_sel   = (line_control_in == uiifc_pkg::UIIFC_LC_ENH_KEY)
                      && !supp_efr_hide_in;
   assign gate_on   = enhanced_features_out[uiifc_pkg::UIIFC_EF_GATE_BIT];
   assign wr_dlh    = reg_wr_in && latch_sel
                      && (line_control_in != uiifc_pkg::UIIFC_LC_ENH_KEY)
                      && (reg_addr_in
                          == uiifc_pkg::UIIFC_OFS_DIVISOR_HIGH);
   assign wr_ier    = reg_wr_in && !latch_sel
                      && (reg_addr_in == uiifc_pkg::UIIFC_OFS_INT_ENABLE);
   assign wr_fcr    = reg_wr_in && !latch_sel
                      && (reg_addr_in
                          == uiifc_pkg::UIIFC_OFS_FIFO_CTRL);
   assign wr_efr    = reg_wr_in && enh_sel
                      && (reg_addr_in
                          == uiifc_pkg::UIIFC_OFS_ENH_FEAT);
   assign rd_iir    = reg_rd_in && !latch_sel
                      && (reg_addr_in == uiifc_pkg::UIIFC_OFS_IDENT);

   // The divisor byte ignores the soft reset, only the pin reset clears it.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         divisor_high_byte_out <= uiifc_pkg::UIIFC_RST_DIVISOR_HIGH;
      end else if (wr_dlh) begin
         divisor_high_byte_out <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enhanced_features_out <= uiifc_pkg::UIIFC_RST_ENH_FEAT;
      end else if (soft_reset_in) begin
         enhanced_features_out <= uiifc_pkg::UIIFC_RST_ENH_FEAT;
      end else if (wr_efr) begin
         enhanced_features_out <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         interrupt_enable_out <= uiifc_pkg::UIIFC_RST_INT_ENABLE;
      end else if (soft_reset_in) begin
         interrupt_enable_out <= uiifc_pkg::UIIFC_RST_INT_ENABLE;
      end else if (wr_ier) begin
         if (gate_on) begin
            interrupt_enable_out <= reg_wdata_in;
         end else begin
            interrupt_enable_out <= (interrupt_enable_out
                                     & uiifc_pkg::UIIFC_IE_LOCK_MASK)
                                    | (reg_wdata_in
                                       & ~uiifc_pkg::UIIFC_IE_LOCK_MASK);
         end
      end
   end

   // A write with the enable bit low leaves the other fields untouched.
   always_comb begin
      fcr_nxt = fifo_control_out;
      fcr_nxt[uiifc_pkg::UIIFC_FC_ENABLE_BIT] =
         reg_wdata_in[uiifc_pkg::UIIFC_FC_ENABLE_BIT];
      if (reg_wdata_in[uiifc_pkg::UIIFC_FC_ENABLE_BIT]) begin
         fcr_nxt[7:6] = reg_wdata_in[7:6];
         if (gate_on) begin
            fcr_nxt[5:4] = reg_wdata_in[5:4];
         end
      end
      fcr_nxt = fcr_nxt & uiifc_pkg::UIIFC_FC_WRITE_MASK;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fifo_control_out <= uiifc_pkg::UIIFC_RST_FIFO_CTRL;
      end else if (soft_reset_in) begin
         fifo_control_out <= uiifc_pkg::UIIFC_RST_FIFO_CTRL;
      end else if (wr_fcr) begin
         fifo_control_out <= fcr_nxt;
      end
   end

   // Reset strobes last one cycle; shifters outside are not touched.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_fifo_reset_out <= 1'b0;
         rx_fifo_reset_out <= 1'b0;
      end else begin
         tx_fifo_reset_out <= wr_fcr
            && reg_wdata_in[uiifc_pkg::UIIFC_FC_ENABLE_BIT]
            && reg_wdata_in[uiifc_pkg::UIIFC_FC_TXRST_BIT];
         rx_fifo_reset_out <= wr_fcr
            && reg_wdata_in[uiifc_pkg::UIIFC_FC_ENABLE_BIT]
            && reg_wdata_in[uiifc_pkg::UIIFC_FC_RXRST_BIT];
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rx_trigger_out <= uiifc_pkg::UIIFC_TRIG_SINGLE;
         tx_trigger_out <= uiifc_pkg::UIIFC_TRIG_SINGLE;
         fifo_depth_out <= uiifc_pkg::UIIFC_DEPTH_SINGLE;
      end else if (fifo_control_out[uiifc_pkg::UIIFC_FC_ENABLE_BIT]) begin
         rx_trigger_out <=
            uiifc_pkg::UIIFC_RX_TRIG[fifo_control_out[7:6]];
         tx_trigger_out <=
            uiifc_pkg::UIIFC_TX_TRIG[fifo_control_out[5:4]];
         fifo_depth_out <= uiifc_pkg::UIIFC_DEPTH_FIFO;
      end else begin
         rx_trigger_out <= uiifc_pkg::UIIFC_TRIG_SINGLE;
         tx_trigger_out <= uiifc_pkg::UIIFC_TRIG_SINGLE;
         fifo_depth_out <= uiifc_pkg::UIIFC_DEPTH_SINGLE;
      end
   end

   // New detections win over a clear in the same cycle.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         xoff_flag_r <= 1'b0;
      end else if (soft_reset_in) begin
         xoff_flag_r <= 1'b0;
      end else if (flow_stop_det_in) begin
         xoff_flag_r <= 1'b1;
      end else if (flow_resume_det_in) begin
         xoff_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         spec_flag_r <= 1'b0;
      end else if (soft_reset_in) begin
         spec_flag_r <= 1'b0;
      end else if (special_char_det_in) begin
         spec_flag_r <= 1'b1;
      end else if (rd_iir) begin
         spec_flag_r <= 1'b0;
      end
   end

   assign src_gated = {
      (cts_inactive_in && interrupt_enable_out[uiifc_pkg::UIIFC_IE_CTS_BIT])
      || (rts_inactive_in
          && interrupt_enable_out[uiifc_pkg::UIIFC_IE_RTS_BIT]),
      (xoff_flag_r || spec_flag_r)
         && interrupt_enable_out[uiifc_pkg::UIIFC_IE_XOFF_BIT],
      src_pin_change_in,
      src_modem_in && interrupt_enable_out[3],
      src_tx_ready_in && interrupt_enable_out[1],
      src_rx_data_in && interrupt_enable_out[0],
      src_rx_timeout_in && interrupt_enable_out[0],
      src_line_status_in && interrupt_enable_out[2]};

   uiifc_ident_enc u_enc (
      .clk_sys_in (clk_sys_in),
      .arst_n_in  (arst_n_in),
      .src_in     (src_gated),
      .ident_out  (ident_code)
   );

   assign ident_val = {{2{fifo_control_out[uiifc_pkg::UIIFC_FC_ENABLE_BIT]}},
                       ident_code};

   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_addr_in == uiifc_pkg::UIIFC_OFS_IDENT) begin
         if (enh_sel) begin
            rdata_nxt = enhanced_features_out;
         end else if (!latch_sel) begin
            rdata_nxt = ident_val;
         end
      end else if (reg_addr_in == uiifc_pkg::UIIFC_OFS_DIVISOR_HIGH) begin
         if (!latch_sel) begin
            rdata_nxt = interrupt_enable_out;
         end else if (line_control_in != uiifc_pkg::UIIFC_LC_ENH_KEY) begin
            rdata_nxt = divisor_high_byte_out;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out   <= 8'h00;
         int_pending_out <= 1'b0;
      end else begin
         reg_rdata_out   <= reg_rd_in ? rdata_nxt : reg_rdata_out;
         int_pending_out <= !ident_code[0];
      end
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!arst_n_in);

   a_ier_lock_hold: assert property (
      wr_ier && !gate_on && !soft_reset_in |=>
      interrupt_enable_out[7:4] == $past(interrupt_enable_out[7:4]))
      else $error("Locked interrupt enable bits changed.");
   a_dlh_write_lands: assert property (
      wr_dlh |=> divisor_high_byte_out == $past(reg_wdata_in))
      else $error("Divisor upper byte did not take the write.");
   a_pending_bit_tie: assert property (
      ##1 int_pending_out == !$past(ident_code[0]))
      else $error("Pending output disagrees with ident bit 0.");
   a_line_status_top: assert property (
      src_gated[0] |=> ident_code == 6'h06)
      else $error("Line status error not reported first.");
   a_pin_change_code: assert property (
      src_gated[5] && (src_gated[4:0] == 5'h00) |=> ident_code == 6'h30)
      else $error("Pin change code wrong.");
   a_flow_code: assert property (
      src_gated[6] && (src_gated[5:0] == 6'h00) |=> ident_code == 6'h10)
      else $error("Flow or special character code wrong.");
   a_cts_rts_code: assert property (
      (src_gated == 8'h80) |=> ident_code == 6'h20)
      else $error("Clear or request to send code wrong.");
   a_special_read_clear: assert property (
      spec_flag_r && rd_iir && !special_char_det_in && !soft_reset_in
      |=> !spec_flag_r)
      else $error("Special flag survived an ident read.");
   a_fcr_txtrig_lock: assert property (
      wr_fcr && !gate_on && !soft_reset_in |=>
      fifo_control_out[5:4] == $past(fifo_control_out[5:4]))
      else $error("Transmit trigger changed without gate.");
   a_tx_reset_pulse: assert property (
      tx_fifo_reset_out |=> !tx_fifo_reset_out || $past(wr_fcr))
      else $error("Transmit reset strobe did not self clear.");
   a_rx_reset_pulse: assert property (
      wr_fcr && reg_wdata_in[0] && reg_wdata_in[1] |=> rx_fifo_reset_out)
      else $error("Receive reset strobe missing.");
   a_single_trig: assert property (
      !fifo_control_out[0] |=> rx_trigger_out == 7'h01
      && fifo_depth_out == 7'h01)
      else $error("Non FIFO mode trigger or depth wrong.");
   a_rx_trig_map: assert property (
      fifo_control_out[0] && fifo_control_out[7:6] == 2'h3
      |=> rx_trigger_out == 7'h3C)
      else $error("Receive trigger of 60 not applied.");
   a_fifo_depth: assert property (
      fifo_control_out[0] |=> fifo_depth_out == 7'h40)
      else $error("FIFO depth not 64 when enabled.");
   a_mirror_bits: assert property (
      rd_iir |=> reg_rdata_out[7:6] == {2{$past(fifo_control_out[0])}}
      && !fifo_control_out[3])
      else $error("Ident mirror or reserved bit wrong.");
   a_divisor_keep: assert property (
      !wr_dlh |=> divisor_high_byte_out == $past(divisor_high_byte_out))
      else $error("Divisor upper byte changed without a write.");
   a_ident_idle: assert property (
      src_gated == 8'h00 |=> ident_code == 6'h01)
      else $error("Ident does not show idle with no source.");
   a_tx_trig_map: assert property (
      fifo_control_out[0] && fifo_control_out[5:4] == 2'h0
      |=> tx_trigger_out == 7'h08)
      else $error("Transmit trigger of 8 not applied.");
   a_flow_set_wins: assert property (
      flow_stop_det_in && !soft_reset_in |=> xoff_flag_r)
      else $error("Flow-stop detection did not set the flag.");
   a_fcr_off_lock: assert property (
      wr_fcr && !reg_wdata_in[0] && !soft_reset_in
      |=> fifo_control_out[7:4] == $past(fifo_control_out[7:4]))
      else $error("Trigger fields changed with FIFO disabled.");

   c_rx_data_int: cover property (src_gated == 8'h04 ##1 ident_code == 6'h04);
   c_fifo_reset:  cover property (wr_fcr ##1 tx_fifo_reset_out);
   c_spec_read:   cover property (spec_flag_r && rd_iir);
   c_xon_clear:   cover property (xoff_flag_r ##1 flow_resume_det_in);
endmodule

/* bench/uiifc_host.sv */
`timescale 1ns/1ps
// Host side of the register port: one request at a time, set up and
// released on falling edges so each strobe spans exactly one rising edge.
module uiifc_host (
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output logic      [3:0] addr_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic      [7:0] wdata_out
);
   initial begin
      addr_out  = 4'h0;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      wdata_out = 8'h00;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr_out  = a;
      wdata_out = d;
      wr_out    = 1'b1;
      @(negedge clk_in);
      wr_out    = 1'b0;
      // Idle data toggles so a stale value is never mistaken for a write.
      wdata_out = ~d;
      addr_out  = ~a;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      rd_out   = 1'b1;
      @(negedge clk_in);
      rd_out   = 1'b0;
      addr_out = ~a;
      @(negedge clk_in);
      d = rdata_in;
   endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic       clk_sys_in = 1'b0;
   logic       arst_n_in  = 1'b0;
   logic       soft_rst   = 1'b0;
   logic [7:0] line_control        = 8'h00;
   logic       hide       = 1'b0;
   logic [8:0] src        = 9'h000;
   logic       fstop      = 1'b0;
   logic       fres       = 1'b0;
   logic       spec       = 1'b0;
   logic [3:0] addr;
   logic       wr;
   logic       rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] divisor_high_byte;
   logic [7:0] interrupt_enable_reg;
   logic [7:0] enhanced_features;
   logic [7:0] fifo_control;
   logic       txr;
   logic       rxr;
   logic [6:0] rxt;
   logic [6:0] txt;
   logic [6:0] dep;
   logic       pend;
   logic [7:0] v;
   logic [7:0] d;
   logic [1:0] t;
   int         error_cnt = 0;
   int         tests_run = 0;
   int         cyc       = 0;
   int         seed      = 32'hfa0a;
   always #2 clk_sys_in = ~clk_sys_in;
   uiifc_host host (.clk_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
      .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
   uiifc_regs dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .soft_reset_in(soft_rst), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_wdata_in(wdata), .line_control_in(line_control),
      .supp_efr_hide_in(hide), .src_line_status_in(src[0]),
      .src_rx_timeout_in(src[1]), .src_rx_data_in(src[2]),
      .src_tx_ready_in(src[3]), .src_modem_in(src[4]),
      .src_pin_change_in(src[5]), .flow_stop_det_in(fstop),
      .flow_resume_det_in(fres), .special_char_det_in(spec),
      .cts_inactive_in(src[7]), .rts_inactive_in(src[8]),
      .reg_rdata_out(rdata), .divisor_high_byte_out(divisor_high_byte),
      .interrupt_enable_out(interrupt_enable_reg), .enhanced_features_out(enhanced_features),
      .fifo_control_out(fifo_control), .tx_fifo_reset_out(txr),
      .rx_fifo_reset_out(rxr), .rx_trigger_out(rxt), .tx_trigger_out(txt),
      .fifo_depth_out(dep), .int_pending_out(pend));
   // Expected ident code for the most urgent pending source, or none.
   function automatic logic [5:0] top_code(input logic [8:0] s);
      logic [8:0][5:0] c;
      c = {6'h20, 6'h20, 6'h10, 6'h30, 6'h00, 6'h02, 6'h04, 6'h0C, 6'h06};
      for (int i = 0; i < 9; i++) begin
         if (s[i] && i != 6) return c[i];
      end
      return 6'h01;
   endfunction
   function automatic logic [6:0] trig(input logic [1:0] f, input logic rx);
      logic [3:0][6:0] r;
      r = rx ? {7'h3C, 7'h38, 7'h10, 7'h08} : {7'h38, 7'h20, 7'h10, 7'h08};
      return r[f];
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (12) @(negedge clk_sys_in);
      arst_n_in = 1'b1;
      host.rd(4'h2, v);
      chk(v, 8'h01);
      chk(fifo_control, 8'h00);
      chk(divisor_high_byte, 8'h00);
      chk({1'b0, rxt}, 8'h01);
      chk({1'b0, dep}, 8'h01);
      $display("test reset done");
      line_control = 8'h80;
      d = 8'($random(seed));
      host.wr(4'h1, d);
      host.rd(4'h1, v);
      chk(v, d);
      line_control = 8'hBF;
      host.wr(4'h1, ~d);
      chk(divisor_high_byte, d);
      hide = 1'b1;
      host.wr(4'h2, 8'h10);
      chk(enhanced_features, 8'h00);
      line_control = 8'h00;
      host.wr(4'h1, 8'hFF);
      chk(interrupt_enable_reg, 8'h0F);
      host.wr(4'h2, 8'h31);
      chk(fifo_control, 8'h01);
      wait_cyc(1);
      chk({1'b0, txt}, 8'h08);
      line_control = 8'hBF;
      hide = 1'b0;
      host.wr(4'h2, 8'h10);
      chk(enhanced_features, 8'h10);
      line_control = 8'h00;
      host.wr(4'h1, 8'hFF);
      chk(interrupt_enable_reg, 8'hFF);
      $display("test gate done");
      for (int i = 0; i < 4; i++) begin
         t = 2'(i) ^ 2'($random(seed));
         host.wr(4'h2, {2'(i), t, 4'h1});
         wait_cyc(1);
         chk(fifo_control, {2'(i), t, 4'h1});
         chk({1'b0, rxt}, {1'b0, trig(2'(i), 1'b1)});
         chk({1'b0, txt}, {1'b0, trig(t, 1'b0)});
         chk({1'b0, dep}, 8'h40);
      end
      host.wr(4'h2, 8'h0F);
      chk({6'h00, txr, rxr}, 8'h03);
      chk(fifo_control, 8'h01);
      wait_cyc(1);
      chk({6'h00, txr, rxr}, 8'h00);
      host.wr(4'h2, 8'hE1);
      host.wr(4'h2, 8'hF6);
      chk({6'h00, txr, rxr}, 8'h00);
      wait_cyc(1);
      chk(fifo_control, 8'hE0);
      chk({1'b0, rxt}, 8'h01);
      chk({1'b0, txt}, 8'h01);
      chk({1'b0, dep}, 8'h01);
      $display("test fifo control done");
      host.wr(4'h2, 8'h01);
      for (int k = 0; k < 40; k++) begin
         @(negedge clk_sys_in);
         src = (k < 9) ? 9'(1 << k) : 9'($random(seed));
         src[6] = 1'b0;
         wait_cyc(2);
         host.rd(4'h2, v);
         chk(v, {2'b11, top_code(src)});
         chk({7'h00, pend}, {7'h00, src != 9'h000});
      end
      src = 9'h000;
      $display("test priority done");
      fstop = 1'b1;
      wait_cyc(1);
      fstop = 1'b0;
      wait_cyc(2);
      host.rd(4'h2, v);
      chk(v, 8'hD0);
      host.rd(4'h2, v);
      chk(v, 8'hD0);
      fres = 1'b1;
      wait_cyc(1);
      fres = 1'b0;
      wait_cyc(2);
      host.rd(4'h2, v);
      chk(v, 8'hC1);
      spec = 1'b1;
      wait_cyc(1);
      spec = 1'b0;
      wait_cyc(2);
      host.rd(4'h2, v);
      chk(v, 8'hD0);
      wait_cyc(2);
      host.rd(4'h2, v);
      chk(v, 8'hC1);
      host.rd(4'hF, v);
      chk(v, 8'h00);
      $display("test flow flags done");
      soft_rst = 1'b1;
      wait_cyc(1);
      soft_rst = 1'b0;
      wait_cyc(1);
      chk(divisor_high_byte, d);
      chk(fifo_control, 8'h00);
      host.rd(4'h2, v);
      chk(v, 8'h01);
      $display("test soft reset done");
      end_sim();
   end
endmodule
